/* dv/qec_counter_props.sv */
// Port assertions for the counter
`timescale 1ns/1ps
module qec_counter_props
    import qec_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    // Inputs
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic i_quad_input_first_pin,
    input wire logic i_quad_input_second_pin,
    input wire logic i_count_start,
    input wire logic i_free_run,
    input wire qec_proc_t i_proc,
    input wire qec_wr_t i_timer_wr,
    // Outputs
    input wire logic [CNT_W-1:0] o_timer,
    input wire logic [CNT_W-1:0] o_reload,
    input wire logic o_irq
);
default clocking @(posedge i_clk_sys); endclocking
default disable iff (!i_arst_n);
wire wr = i_ce && i_timer_wr.we;
chk_irq_pulse: assert property (o_irq && i_ce |=> !o_irq) else $error("irq wide");
chk_wr_stop: assert property (wr && !i_count_start |=> o_timer == $past(i_timer_wr.wdata)) else $error("wr");
chk_wr_run: assert property (wr && i_count_start |=> o_reload == $past(i_timer_wr.wdata)) else $error("wr");
chk_stop_hold: assert property (i_ce && !i_count_start && !wr |=> $stable(o_timer)) else $error("hold");
chk_wrap_load: assert property (o_irq && !$past(i_free_run) && !$past(wr) |-> o_timer == o_reload)
    else $error("reload");
chk_free_wrap: assert property (o_irq && $past(i_free_run) |-> o_timer == 0 || o_timer == '1)
    else $error("wrap");
chk_unit_step: assert property (!$past(wr) && !o_irq && $changed(o_timer)
    |-> o_timer == $past(o_timer) + 1'b1 || o_timer == $past(o_timer) - 1'b1) else $error("step");
chk_sync_lag: assert property (!$past(wr) && $changed(o_timer) |-> $past({i_quad_input_first_pin,
    i_quad_input_second_pin}, 3) != $past({i_quad_input_first_pin, i_quad_input_second_pin}, 4)) else $error("lag");
endmodule
bind qec_counter qec_counter_props #(.CNT_W(CNT_W)) u_qec_counter_props(.i_clk_sys, .i_arst_n, .i_ce,
    .i_quad_input_first_pin, .i_quad_input_second_pin, .i_count_start, .i_free_run, .i_proc, .i_timer_wr,
    .o_timer, .o_reload, .o_irq);

/* dv/qec_quad_src.sv */
// Two-phase encoder model
`timescale 1ns/1ps
module qec_quad_src (
    // Clock
    input wire logic i_clk_sys,
    // Pins
    output logic o_first,
    output logic o_second
);
logic [1:0] ph = 2'h0;
// Up order (first, second): 00,01,11,10; pins stay inputs on the device side
assign o_first = ph[1];
assign o_second = ph[0] ^ ph[1];
task step(int dir, int n);
    for (int k = 0; k < n; k++) begin
        ph = ph + 2'(dir);
        repeat (4) @(negedge i_clk_sys);
    end
endtask
endmodule

/* dv/quadrature_event_counter_test.sv */
// Testbench for the counter
`timescale 1ns/1ps
module quadrature_event_counter_test;
import qec_pkg::*;
logic i_clk_sys = 0, i_arst_n = 0, i_ce = 1, run = 0, free = 0, fp, sp, o_irq;
qec_proc_t pr = QEC_PROC_X4;
qec_wr_t w = '0;
logic [15:0] o_timer, o_reload;
int err_count = 0, samples_checked = 0, irqs = 0, cyc = 0;
always #10 i_clk_sys = ~i_clk_sys;
qec_quad_src u_qec_quad_src(.i_clk_sys, .o_first(fp), .o_second(sp));
qec_counter u_qec_counter(.i_clk_sys, .i_arst_n, .i_ce, .i_quad_input_first_pin(fp), .i_quad_input_second_pin(sp),
    .i_count_start(run), .i_free_run(free), .i_proc(pr), .i_timer_wr(w), .o_timer, .o_reload, .o_irq);
always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    irqs <= irqs + (o_irq === 1'b1);
    if (cyc == 4000) begin
        err_count++;
        end_sim();
    end
end
task ck(string s, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
        $display("BAD %s exp %h got %h", s, e, g);
        err_count++;
    end
endtask
task wr(logic [15:0] v);
    @(negedge i_clk_sys) w = {1'b1, v};
    @(negedge i_clk_sys) w.we = 0;
endtask
task mv(int d, int n, string s, logic [15:0] e);
    u_qec_quad_src.step(d, n);
    ck(s, e, o_timer);
endtask
task end_sim;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
initial begin
    repeat (12) @(negedge i_clk_sys);
    i_arst_n = 1;
    wr(16'h1234);
    ck("load", 16'h1234, o_reload);
    run = 1;
    mv(1, 4, "x4 up", 16'h1238);
    wr(16'h0005);
    ck("run wr", 16'h1238, o_timer);
    mv(-1, 8, "x4 dn", 16'h1230);
    pr = QEC_PROC_NORMAL;
    mv(1, 8, "norm up", 16'h1232);
    mv(-1, 4, "norm dn", 16'h1231);
    pr = QEC_PROC_X4;
    run = 0;
    mv(1, 4, "hold", 16'h1231);
    wr(16'hfffe);
    run = 1;
    mv(1, 4, "up wrap", 16'hfffe);
    ck("irqs", 16'h0002, 16'(irqs));
    run = 0;
    wr(16'h0001);
    run = 1;
    mv(-1, 2, "dn wrap", 16'h0001);
    run = 0;
    wr(16'hffff);
    free = 1;
    run = 1;
    mv(1, 1, "free", 16'h0000);
    ck("irqs", 16'h0004, 16'(irqs));
    end_sim();
end
endmodule

/* src/qec_counter.sv */
// Sixteen-bit quadrature event counter channel with reload
`timescale 1ns/1ps
`include "qec_map.svh"
module qec_counter
    import qec_pkg::*;
#(
    parameter int CNT_W = `QEC_CNT_W
)
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // Quadrature pins, direction bits must be input
    input wire logic i_quad_input_first_pin,
    input wire logic i_quad_input_second_pin,
    // Control
    input wire logic i_count_start,
    input wire logic i_free_run,
    input wire qec_proc_t i_proc,
    input wire qec_wr_t i_timer_wr,
    // Status
    output logic [CNT_W-1:0] o_timer,
    output logic [CNT_W-1:0] o_reload,
    output logic o_irq
);
    qec_step_t step;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] reload;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] next_reload;
    logic [CNT_W-1:0] wr_value;
    logic [CNT_W-1:0] count_inc;
    logic [CNT_W-1:0] count_dec;
    logic next_irq;
    logic run;
    logic wr_req;
    logic step_up;
    logic step_down;
    logic at_max;
    logic at_min;
    logic wrap_up;
    logic wrap_down;
    logic wrap_any;
    logic take_reload;
    logic load_write;

    // Events come from pins only; keeps them as inputs
    qec_decoder u_dec (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_quad_input_first_pin(i_quad_input_first_pin),
        .i_quad_input_second_pin(i_quad_input_second_pin),
        .i_proc(i_proc),
        .o_step(step)
    );

    // Count-start is a level; dropping it freezes the count in place
    assign run = i_count_start;
    assign wr_req = i_timer_wr.we;
    assign wr_value = i_timer_wr.wdata[CNT_W-1:0];

    // Steps only count while running; up wins a contradictory pair
    assign step_up = run & step.step_up;
    assign step_down = run & step.step_down & ~step.step_up;

    // Wrap points: past all ones going up, below zero going down
    assign at_max = (count == CNT_W'(`QEC_CNT_MAX));
    assign at_min = (count == CNT_W'(`QEC_CNT_MIN));
    assign wrap_up = step_up & at_max;
    assign wrap_down = step_down & at_min;
    assign wrap_any = wrap_up | wrap_down;

    // Free-running skips the reload and lets the adder wrap
    assign take_reload = wrap_any & ~i_free_run;
    assign load_write = ~run & wr_req;
    assign count_inc = count + CNT_W'(1);
    assign count_dec = count - CNT_W'(1);

    // Reload register takes every write, running or not
    always_comb begin
        next_reload = reload;
        if (wr_req) begin
            next_reload = wr_value;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            reload <= CNT_W'(`QEC_RELOAD_RST);
        end else if (i_ce) begin
            reload <= next_reload;
        end
    end

    // Reload yields ffff-n+1 up steps or n+1 down steps per wrap.
    // A write landing with a wrap reaches the counter only at the next wrap.
    always_comb begin
        next_count = count;
        if (load_write) begin
            next_count = wr_value;
        end else if (take_reload) begin
            next_count = reload;
        end else if (step_up) begin
            next_count = count_inc;
        end else if (step_down) begin
            next_count = count_dec;
        end
    end

    assign next_irq = wrap_any;

    // Stopped counter takes a write at once; a write while running reaches it only on reload
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count <= CNT_W'(`QEC_CNT_RST);
        end else if (i_ce) begin
            count <= next_count;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_irq <= next_irq;
        end
    end

    assign o_timer = count;
    assign o_reload = reload;
endmodule

/* src/qec_decoder.sv */
// Quadrature pin synchroniser and step decoder
`timescale 1ns/1ps
`include "qec_map.svh"
module qec_decoder
    import qec_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // Pins and mode
    input wire logic i_quad_input_first_pin,
    input wire logic i_quad_input_second_pin,
    input wire qec_proc_t i_proc,
    // Step out
    output qec_step_t o_step
);
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] prev;
    logic a;
    logic b;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;

    // Two sync stages per pin plus a previous-value stage; edges compare the second and third
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta <= 2'h0;
            sync <= 2'h0;
            prev <= 2'h0;
        end else if (i_ce) begin
            meta <= {i_quad_input_second_pin, i_quad_input_first_pin};
            sync <= meta;
            prev <= sync;
        end
    end

    assign a = sync[0];
    assign b = sync[1];
    assign a_rise = a & ~prev[0];
    assign a_fall = ~a & prev[0];
    assign b_rise = b & ~prev[1];
    assign b_fall = ~b & prev[1];

    // Direction comes only from the phase of the two pins
    always_comb begin
        o_step = '0;
        if (i_ce) begin
            if (i_proc == QEC_PROC_NORMAL) begin
                o_step.step_up = a_rise & b;
                o_step.step_down = a_fall & b;
            end else begin
                // Up order (first, second): 00, 01, 11, 10; first rising while second high
                o_step.step_up = (a_rise & b) | (b_rise & ~a) | (a_fall & ~b) | (b_fall & a);
                o_step.step_down = (a_rise & ~b) | (b_rise & a) | (a_fall & b) | (b_fall & ~a);
            end
        end
    end
endmodule

/* src/qec_map.svh */
// Constants for the quadrature event counter
`ifndef QEC_MAP_SVH
`define QEC_MAP_SVH
`define QEC_CNT_W 16
`define QEC_CNT_MAX 16'hffff
`define QEC_CNT_MIN 16'h0000
`define QEC_CNT_RST 16'h0000
`define QEC_RELOAD_RST 16'h0000
`define QEC_SYNC_STAGES 2
`endif

/* src/qec_pkg.sv */
// Types for the quadrature event counter
package qec_pkg;
    typedef enum logic [1:0] {
        QEC_PROC_NORMAL,
        QEC_PROC_X4
    } qec_proc_t;
    typedef struct packed {
        logic we;
        logic [15:0] wdata;
    } qec_wr_t;
    typedef struct packed {
        logic step_up;
        logic step_down;
    } qec_step_t;
endpackage
